// [swfc_pkg.sv]
// Constants and types shared by the software flow control block
package swfc_pkg;

  // ----------------------------------------
  // Register offsets on the host port
  // ----------------------------------------
  localparam logic [3:0] ADDR_EFC = 4'h0;
  localparam logic [3:0] ADDR_SUSP1 = 4'h1;
  localparam logic [3:0] ADDR_SUSP2 = 4'h2;
  localparam logic [3:0] ADDR_RES1 = 4'h3;
  localparam logic [3:0] ADDR_RES2 = 4'h4;
  localparam logic [3:0] ADDR_CCS = 4'h5;
  localparam logic [3:0] ADDR_ISS = 4'h6;
  localparam logic [3:0] ADDR_LS = 4'h7;
  localparam logic [3:0] ADDR_MS = 4'h8;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] EFC_RST = 8'h00;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [3:0] CCS_RST = 4'h0;
  localparam logic [3:0] MS_DELTA_RST = 4'h0;
  localparam logic [3:0] MODEM_SYNC_RST = 4'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CCS_TX_RES = 3;
  localparam int CCS_TX_SUS = 2;
  localparam int CCS_RX_RES = 1;
  localparam int CCS_RX_SUS = 0;
  localparam int EFC_SPECIAL = 5;
  localparam int ISS_NONE = 0;
  localparam int ISS_FLOW = 4;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_SHIFT_EMPTY = 6;

  // ----------------------------------------
  // Selector codes for either half of the selector
  // ----------------------------------------
  localparam logic [1:0] SEL_NONE = 2'b00;
  localparam logic [1:0] SEL_FIRST = 2'b10;
  localparam logic [1:0] SEL_SECOND = 2'b01;
  localparam logic [1:0] SEL_BOTH = 2'b11;

  // Control character sender states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_CHAR1 = 2'b01,
    TX_CHAR2 = 2'b10
  } tx_state_t;

endpackage

// [swfc_match_if.sv]
// Link between the register side and the receive matcher
`timescale 1ns/10ps
interface swfc_match_if;
  logic [7:0] susp1;
  logic [7:0] susp2;
  logic [7:0] res1;
  logic [7:0] res2;
  logic [3:0] sel;
  logic special_en;
  logic [7:0] rx_data;
  logic rx_valid;
  logic resume_evt;
  logic suspend_evt;
  logic special_evt;
  logic fwd_valid;
  logic [7:0] fwd_data;

  modport ctrl (
    output susp1, susp2, res1, res2, sel, special_en, rx_data, rx_valid,
    input resume_evt, suspend_evt, special_evt, fwd_valid, fwd_data
  );
  modport matcher (
    input susp1, susp2, res1, res2, sel, special_en, rx_data, rx_valid,
    output resume_evt, suspend_evt, special_evt, fwd_valid, fwd_data
  );
endinterface

// [uart_swfc_rx_match.sv]
// Receive side matcher for resume and suspend characters
`timescale 1ns/10ps
module uart_swfc_rx_match (
  // Clock and reset
  input logic clk,
  input logic nrst,
  // Characters, selector and events
  swfc_match_if.matcher m
);
  import swfc_pkg::*;

  logic [1:0] rx_mode;
  logic [1:0] tx_mode;
  logic seq_mode;
  logic either_mode;
  logic is_r1, is_r2, is_s1, is_s2;
  logic hit_res, hit_sus, ctrl_hit;
  logic armed_res, armed_sus;
  logic next_armed_res, next_armed_sus;
  logic next_res_evt, next_sus_evt, next_spec_evt, next_fwd_valid;
  logic [7:0] next_fwd_data;

  // ----------------------------------------
  // Match decode
  // ----------------------------------------
  // Pair mode arms on a first character and fires only on its second
  always_comb
  begin
    rx_mode = m.sel[1:0];
    tx_mode = m.sel[3:2];
    seq_mode = (rx_mode == SEL_BOTH) && (tx_mode == SEL_BOTH || tx_mode == SEL_NONE); // R5
    either_mode = (rx_mode == SEL_BOTH) && !seq_mode; // R4
    is_r1 = (m.rx_data == m.res1);
    is_r2 = (m.rx_data == m.res2);
    is_s1 = (m.rx_data == m.susp1);
    is_s2 = (m.rx_data == m.susp2);
    hit_res = 1'b0;
    hit_sus = 1'b0;
    next_armed_res = armed_res;
    next_armed_sus = armed_sus;
    if (m.rx_valid)
    begin
      case (rx_mode)
        SEL_FIRST:
        begin
          hit_res = is_r1; // R3
          hit_sus = is_s1; // R3
        end
        SEL_SECOND:
        begin
          hit_res = is_r2; // R3
          hit_sus = is_s2; // R3
        end
        SEL_BOTH:
        begin
          if (either_mode)
          begin
            hit_res = is_r1 || is_r2; // R4
            hit_sus = is_s1 || is_s2; // R4
          end
          else
          begin
            hit_res = armed_res && is_r2; // R5
            hit_sus = armed_sus && is_s2; // R5
          end
        end
        default:
        begin
          hit_res = 1'b0; // R1
          hit_sus = 1'b0;
        end
      endcase
      next_armed_res = seq_mode && is_r1;
      next_armed_sus = seq_mode && is_s1;
    end
    if (!seq_mode)
    begin
      next_armed_res = 1'b0;
      next_armed_sus = 1'b0;
    end
    // Matched flow characters and pair-mode first characters are consumed, never stored
    ctrl_hit = hit_res || hit_sus || (seq_mode && m.rx_valid && (is_r1 || is_s1));
    next_res_evt = hit_res;
    next_sus_evt = hit_sus;
    next_spec_evt = m.rx_valid && m.special_en && is_s2; // R16
    next_fwd_valid = m.rx_valid && !ctrl_hit; // R16
    next_fwd_data = m.rx_valid ? m.rx_data : m.fwd_data;
  end

  // Event and forward registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      armed_res <= 1'b0;
      armed_sus <= 1'b0;
      m.resume_evt <= 1'b0;
      m.suspend_evt <= 1'b0;
      m.special_evt <= 1'b0;
      m.fwd_valid <= 1'b0;
      m.fwd_data <= CHAR_RST;
    end
    else
    begin
      armed_res <= next_armed_res;
      armed_sus <= next_armed_sus;
      m.resume_evt <= next_res_evt;
      m.suspend_evt <= next_sus_evt;
      m.special_evt <= next_spec_evt;
      m.fwd_valid <= next_fwd_valid;
      m.fwd_data <= next_fwd_data;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rx_first_pair: assert property (@(posedge clk) disable iff (!nrst) // R3
    (rx_mode == SEL_FIRST && m.rx_valid && is_s1) |=> m.suspend_evt)
    else $error("first pair suspend not detected");
  a_rx_off_quiet: assert property (@(posedge clk) disable iff (!nrst) // R1
    (rx_mode == SEL_NONE) |=> !m.resume_evt && !m.suspend_evt)
    else $error("match event while receive matching off");
  a_rx_either_res: assert property (@(posedge clk) disable iff (!nrst) // R4
    (either_mode && m.rx_valid && is_r2) |=> m.resume_evt && !m.fwd_valid)
    else $error("either-mode resume not detected");
  a_rx_pair_seq: assert property (@(posedge clk) disable iff (!nrst) // R5
    (seq_mode && m.rx_valid && is_s1) ##1 (seq_mode && m.rx_valid && is_s2)
    |=> m.suspend_evt)
    else $error("suspend pair not detected");
  a_second_susp_drop: assert property (@(posedge clk) disable iff (!nrst) // R16
    (rx_mode == SEL_SECOND && m.rx_valid && is_s2 && m.special_en)
    |=> m.suspend_evt && m.special_evt && !m.fwd_valid)
    else $error("second suspend stored or not flagged");
  c_rx_pair_resume: cover property (@(posedge clk) disable iff (!nrst)
    seq_mode && m.resume_evt);
endmodule

// [uart_swfc_top.sv]
// Software flow control for one UART channel: registers, sender, halt
// ----------------------------------------
// Summary of operation
// R1: Selector all zero disables flow control; reset value
// R2: Bits 3:2 choose first, second or both transmitted
// R3: Bits 1:0 choose receive compare pair or none
// R4: Modes 1011/0111 receive either pair as match
// R5: Modes 1111/0011 receive needs both characters in order
// R6: Four write-only suspend and resume character registers
// R7: Status register cleared whenever flow control disabled
// R8: Status bit 3: last sent was resume
// R9: Status bit 2: last sent was suspend
// R10: Status bit 1: last received was resume
// R11: Status bit 0: last received was suspend
// R12: Reset values of status, features and characters
// R13: Modem status low nibble cleared at reset
// R14: Reset drives transmit high, infrared low, modem high
// R15: Software zeroes selector before writing new setting
// R16: Second suspend in second-pair mode is dropped, flagged
// R17: Suspend halts transmitter until resume is received
// ----------------------------------------
`timescale 1ns/10ps
module uart_swfc_top (
  // Clock and reset
  input logic clk,
  input logic nrst,
  // Host register port, same clock
  input logic bus_cs,
  input logic bus_wr,
  input logic bus_rd,
  input logic [3:0] bus_addr,
  input logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Transmit data from the host FIFO
  input logic [7:0] tx_data,
  input logic tx_valid,
  output logic tx_ready,
  // Characters to the transmit shifter
  output logic [7:0] ser_data,
  output logic ser_valid,
  input logic ser_ready,
  // Characters from the receive shifter
  input logic [7:0] rx_data,
  input logic rx_valid,
  // Characters to the receive FIFO and events
  output logic [7:0] fifo_data,
  output logic fifo_valid,
  output logic suspend_irq,
  output logic special_irq,
  output logic tx_halted,
  // Send requests from receive FIFO level logic
  input logic req_suspend,
  input logic req_resume,
  // Modem input pins
  input logic [3:0] modem_in,
  // Serial and modem output pins
  output logic tx_pin,
  output logic infrared_transmit_out,
  output logic rts_n,
  output logic dtr_n
);
  import swfc_pkg::*;

  swfc_match_if m ();

  logic [7:0] enhanced_feature_control, next_efc;
  logic [7:0] suspend_char_first, suspend_char_second;
  logic [7:0] resume_char_first, resume_char_second;
  logic [7:0] next_s1, next_s2, next_r1, next_r2;
  logic [3:0] ccs, next_ccs;
  logic iss_flow, next_iss_flow;
  logic [3:0] ms_delta, next_ms_delta;
  logic [3:0] modem_m1, modem_m2, modem_m3;
  logic [7:0] next_rdata;
  logic wr, rd, flow_off;
  logic [1:0] tx_mode;
  tx_state_t tx_state, next_tx_state;
  logic pend_valid, next_pend_valid, pend_resume, next_pend_resume;
  logic cur_resume, next_cur_resume;
  logic next_ser_valid, next_tx_ready, next_halted, taken, take_data;
  logic [7:0] next_ser_data;
  logic done_res, done_sus;

  // Pick a control character by pair slot and kind
  function automatic logic [7:0] ctrl_char(input logic second, input logic resume,
      input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] s1, input logic [7:0] s2);
    ctrl_char = resume ? (second ? r2 : r1) : (second ? s2 : s1);
  endfunction

  // ----------------------------------------
  // Matcher hookup
  // ----------------------------------------
  assign m.susp1 = suspend_char_first;
  assign m.susp2 = suspend_char_second;
  assign m.res1 = resume_char_first;
  assign m.res2 = resume_char_second;
  assign m.sel = enhanced_feature_control[3:0];
  assign m.special_en = enhanced_feature_control[EFC_SPECIAL];
  assign m.rx_data = rx_data;
  assign m.rx_valid = rx_valid;
  assign fifo_data = m.fwd_data;
  assign fifo_valid = m.fwd_valid;
  assign suspend_irq = m.suspend_evt;
  assign special_irq = m.special_evt;

  uart_swfc_rx_match u_match (
    .clk(clk),
    .nrst(nrst),
    .m(m.matcher)
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Status bits: a new event beats a read clear in the same cycle
  always_comb
  begin
    wr = bus_cs && bus_wr;
    rd = bus_cs && bus_rd;
    next_efc = enhanced_feature_control;
    next_s1 = suspend_char_first;
    next_s2 = suspend_char_second;
    next_r1 = resume_char_first;
    next_r2 = resume_char_second;
    if (wr && bus_addr == ADDR_EFC) next_efc = bus_wdata;
    if (wr && bus_addr == ADDR_SUSP1) next_s1 = bus_wdata; // R6
    if (wr && bus_addr == ADDR_SUSP2) next_s2 = bus_wdata; // R6
    if (wr && bus_addr == ADDR_RES1) next_r1 = bus_wdata; // R6
    if (wr && bus_addr == ADDR_RES2) next_r2 = bus_wdata; // R6
    flow_off = (enhanced_feature_control[3:0] == 4'h0); // R1
    next_ccs = ccs;
    if (rd && bus_addr == ADDR_CCS) next_ccs = 4'h0; // R8
    if (done_res) next_ccs[CCS_TX_RES:CCS_TX_SUS] = 2'b10; // R8
    if (done_sus) next_ccs[CCS_TX_RES:CCS_TX_SUS] = 2'b01; // R9
    if (m.resume_evt) next_ccs[CCS_RX_RES] = 1'b1; // R10
    if (m.resume_evt) next_ccs[CCS_RX_SUS] = 1'b0;
    if (m.suspend_evt) next_ccs[CCS_RX_SUS] = 1'b1; // R11
    if (m.suspend_evt) next_ccs[CCS_RX_RES] = 1'b0;
    if (flow_off) next_ccs = 4'h0; // R7
    next_iss_flow = iss_flow;
    if (rd && bus_addr == ADDR_ISS) next_iss_flow = 1'b0;
    if (m.suspend_evt || m.special_evt) next_iss_flow = 1'b1; // R16
    next_ms_delta = ms_delta;
    if (rd && bus_addr == ADDR_MS) next_ms_delta = 4'h0;
    next_ms_delta = next_ms_delta | (modem_m2 ^ modem_m3);
    // Write-only character registers read back as zero
    next_rdata = bus_rdata;
    if (rd)
    begin
      case (bus_addr)
        ADDR_EFC: next_rdata = enhanced_feature_control;
        ADDR_CCS: next_rdata = {4'h0, ccs}; // R7
        ADDR_ISS: next_rdata = {3'h0, iss_flow, 3'h0, !iss_flow};
        ADDR_LS: next_rdata = {1'b0, !ser_valid, !ser_valid, 5'h00};
        ADDR_MS: next_rdata = {modem_m2, ms_delta};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register file flops; modem pins pass two stages first
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      enhanced_feature_control <= EFC_RST; // R12
      suspend_char_first <= CHAR_RST; // R12
      suspend_char_second <= CHAR_RST;
      resume_char_first <= CHAR_RST;
      resume_char_second <= CHAR_RST;
      ccs <= CCS_RST;
      iss_flow <= 1'b0;
      ms_delta <= MS_DELTA_RST; // R13
      modem_m1 <= MODEM_SYNC_RST;
      modem_m2 <= MODEM_SYNC_RST;
      modem_m3 <= MODEM_SYNC_RST;
      bus_rdata <= 8'h00;
    end
    else
    begin
      enhanced_feature_control <= next_efc;
      suspend_char_first <= next_s1;
      suspend_char_second <= next_s2;
      resume_char_first <= next_r1;
      resume_char_second <= next_r2;
      ccs <= next_ccs;
      iss_flow <= next_iss_flow;
      ms_delta <= next_ms_delta;
      modem_m1 <= modem_in;
      modem_m2 <= modem_m1;
      modem_m3 <= modem_m2;
      bus_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Control character sender and data path
  // ----------------------------------------
  // Control characters jump ahead of data; data stops while halted
  always_comb
  begin
    tx_mode = enhanced_feature_control[3:2];
    taken = ser_valid && ser_ready;
    take_data = tx_valid && tx_ready;
    next_ser_valid = taken ? 1'b0 : ser_valid;
    next_ser_data = ser_data;
    next_tx_state = tx_state;
    next_pend_valid = pend_valid;
    next_pend_resume = pend_resume;
    next_cur_resume = cur_resume;
    done_res = 1'b0;
    done_sus = 1'b0;
    case (tx_state)
      TX_IDLE:
      begin
        if (take_data)
        begin
          next_ser_data = tx_data;
          next_ser_valid = 1'b1;
        end
        else if (pend_valid && (!ser_valid || taken))
        begin
          next_ser_data = ctrl_char(tx_mode == SEL_SECOND, pend_resume, resume_char_first,
            resume_char_second, suspend_char_first, suspend_char_second); // R2
          next_ser_valid = 1'b1;
          next_cur_resume = pend_resume;
          next_pend_valid = 1'b0;
          next_tx_state = TX_CHAR1;
        end
      end
      TX_CHAR1:
      begin
        if (taken && tx_mode == SEL_BOTH)
        begin
          next_ser_data = ctrl_char(1'b1, cur_resume, resume_char_first,
            resume_char_second, suspend_char_first, suspend_char_second); // R2
          next_ser_valid = 1'b1;
          next_tx_state = TX_CHAR2;
        end
        else if (taken)
        begin
          done_res = cur_resume; // R8
          done_sus = !cur_resume; // R9
          next_tx_state = TX_IDLE;
        end
      end
      TX_CHAR2:
      begin
        if (taken)
        begin
          done_res = cur_resume; // R8
          done_sus = !cur_resume; // R9
          next_tx_state = TX_IDLE;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
    // A new request beats the clear of the one just started
    if ((req_resume || req_suspend) && tx_mode != SEL_NONE) // R2
    begin
      next_pend_valid = 1'b1;
      next_pend_resume = req_resume;
    end
    if (tx_mode == SEL_NONE) next_pend_valid = 1'b0; // R1
    next_halted = tx_halted;
    if (m.suspend_evt) next_halted = 1'b1; // R17
    if (m.resume_evt) next_halted = 1'b0; // R17
    if (enhanced_feature_control[1:0] == SEL_NONE) next_halted = 1'b0; // R1
    // Registered ready: offered only when the slot is free next cycle
    next_tx_ready = !next_ser_valid && next_tx_state == TX_IDLE
      && !next_pend_valid && !next_halted; // R17
  end

  // Sender flops; pins hold their idle levels for the shifter to take over
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_state <= TX_IDLE;
      pend_valid <= 1'b0;
      pend_resume <= 1'b0;
      cur_resume <= 1'b0;
      ser_valid <= 1'b0;
      ser_data <= CHAR_RST;
      tx_ready <= 1'b0;
      tx_halted <= 1'b0;
      tx_pin <= 1'b1; // R14
      infrared_transmit_out <= 1'b0; // R14
      rts_n <= 1'b1; // R14
      dtr_n <= 1'b1; // R14
    end
    else
    begin
      tx_state <= next_tx_state;
      pend_valid <= next_pend_valid;
      pend_resume <= next_pend_resume;
      cur_resume <= next_cur_resume;
      ser_valid <= next_ser_valid;
      ser_data <= next_ser_data;
      tx_ready <= next_tx_ready;
      tx_halted <= next_halted;
      tx_pin <= 1'b1;
      infrared_transmit_out <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_flow_off_status: assert property ( // R7
    (enhanced_feature_control[3:0] == 4'h0) |=> (ccs == 4'h0))
    else $error("status not cleared with flow control off");
  a_off_no_pending: assert property ( // R1
    (tx_mode == SEL_NONE) |=> !pend_valid)
    else $error("request kept while transmit flow off");
  a_tx_first_char: assert property ( // R2
    (tx_state == TX_IDLE && pend_valid && !take_data && !ser_valid && tx_mode == SEL_FIRST)
    |=> ser_valid && ser_data == ($past(pend_resume) ? resume_char_first : suspend_char_first))
    else $error("wrong first control character sent");
  a_tx_pair_second: assert property ( // R2
    (tx_state == TX_CHAR1 && taken && tx_mode == SEL_BOTH)
    |=> tx_state == TX_CHAR2 && ser_valid)
    else $error("second character of pair not sent");
  a_tx_resume_flag: assert property ( // R8
    (done_res && !flow_off) |=> ccs[CCS_TX_RES] && !ccs[CCS_TX_SUS])
    else $error("sent resume not reported");
  a_tx_suspend_flag: assert property ( // R9
    (done_sus && !flow_off) |=> ccs[CCS_TX_SUS] && !ccs[CCS_TX_RES])
    else $error("sent suspend not reported");
  a_rx_resume_flag: assert property ( // R10
    (m.resume_evt && !m.suspend_evt && !flow_off) |=> ccs[CCS_RX_RES])
    else $error("received resume not reported");
  a_rx_suspend_flag: assert property ( // R11
    (m.suspend_evt && !m.resume_evt && !flow_off) |=> ccs[CCS_RX_SUS])
    else $error("received suspend not reported");
  a_status_read_clear: assert property ( // R8
    (rd && bus_addr == ADDR_CCS && !done_res && !done_sus && !m.resume_evt && !m.suspend_evt)
    |=> ccs == 4'h0 && bus_rdata[7:4] == 4'h0)
    else $error("status read did not clear");
  a_char_write: assert property ( // R6
    (wr && bus_addr == ADDR_SUSP1) |=> suspend_char_first == $past(bus_wdata))
    else $error("suspend character write lost");
  a_halt_blocks: assert property ( // R17
    (m.suspend_evt && !m.resume_evt && enhanced_feature_control[1:0] != SEL_NONE)
    |=> tx_halted && !tx_ready)
    else $error("transmitter not halted on suspend");
  a_reset_values: assert property (disable iff (1'b0) // R12
    !nrst |=> enhanced_feature_control == EFC_RST && ccs == CCS_RST
      && suspend_char_second == CHAR_RST)
    else $error("bad register reset value");
  a_reset_pins: assert property (disable iff (1'b0) // R14
    !nrst |=> tx_pin && !infrared_transmit_out && rts_n && dtr_n && ms_delta == MS_DELTA_RST)
    else $error("bad pin level in reset");

  c_pair_sent: cover property (tx_state == TX_CHAR2 && taken);
  c_halt_resume: cover property (tx_halted ##[1:50] !tx_halted);
  c_status_read: cover property (rd && bus_addr == ADDR_CCS && ccs != 4'h0);
endmodule

// [swfc_peer.sv]
// Remote serial peer model: takes sent characters, injects received ones
`timescale 1ns/10ps
module swfc_peer (
  // Clock
  input logic clk,
  // Characters from the block
  input logic [7:0] ser_data,
  input logic ser_valid,
  output logic ser_ready,
  // Characters into the block
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [7:0] got[$];
  logic stall = 1'b0;
  // ----------------------------------------
  // Sending side
  // ----------------------------------------
  // Ready only every other cycle, so a held character must stay put
  assign ser_ready = ser_valid & ~stall;
  always @(posedge clk)
  begin
    stall <= ~stall;
    if (ser_valid && ser_ready)
      got.push_back(ser_data);
  end
  // ----------------------------------------
  // Receiving side
  // ----------------------------------------
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // One pulse per character; stale data is inverted so it cannot match
  task automatic send(input logic [7:0] c);
    @(negedge clk);
    {rx_data, rx_valid} = {c, 1'b1};
    @(negedge clk);
    {rx_data, rx_valid} = {~c, 1'b0};
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the software flow control block
`timescale 1ns/10ps
module tb;
  import swfc_pkg::*;
  logic clk, nrst, bus_cs, bus_wr, bus_rd, tx_valid, req_suspend, req_resume;
  logic [3:0] bus_addr, modem_in;
  logic [7:0] bus_wdata, bus_rdata, ser_data, rx_data, fifo_data, tx_data;
  logic tx_ready, ser_valid, ser_ready, rx_valid, fifo_valid, suspend_irq, special_irq;
  logic tx_halted, tx_pin, ir_out, rts_n, dtr_n;
  logic [7:0] ch [1:4] = '{8'h13, 8'h93, 8'h11, 8'h91};
  int n_mismatch = 0;
  int num_checks = 0;
  int n_fifo = 0;
  int n_susp = 0;
  int n_spec = 0;
  uart_swfc_top DUT (.clk(clk), .nrst(nrst), .bus_cs(bus_cs), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .ser_data(ser_data),
    .ser_valid(ser_valid), .ser_ready(ser_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .fifo_data(fifo_data), .fifo_valid(fifo_valid), .suspend_irq(suspend_irq),
    .special_irq(special_irq), .tx_halted(tx_halted), .req_suspend(req_suspend),
    .req_resume(req_resume), .modem_in(modem_in), .tx_pin(tx_pin),
    .infrared_transmit_out(ir_out), .rts_n(rts_n), .dtr_n(dtr_n));
  swfc_peer peer (.clk(clk), .ser_data(ser_data), .ser_valid(ser_valid),
    .ser_ready(ser_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {bus_cs, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
    @(negedge clk);
    {bus_cs, bus_wr} = 2'b00;
  endtask
  // Read data is registered, so it is settled at the next falling edge
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    {bus_cs, bus_rd, bus_addr} = {2'b11, a};
    @(negedge clk);
    {bus_cs, bus_rd} = 2'b00;
    chk(bus_rdata, e);
  endtask
  task automatic req(input logic s);
    @(negedge clk);
    {req_suspend, req_resume} = s ? 2'b10 : 2'b01;
    @(negedge clk);
    {req_suspend, req_resume} = 2'b00;
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 40 && peer.got.size() < n; i++)
      @(negedge clk);
    if (peer.got.size() < n)
    begin
      n_mismatch++;
      complete_run;
    end
  endtask
  // Selector goes through zero before every new mode
  task automatic mode(input logic [7:0] m);
    wr(ADDR_EFC, 8'h00);
    wr(ADDR_EFC, m);
    peer.got.delete();
    // Pulse counts start afresh with each mode
    {n_fifo, n_susp, n_spec} = '0;
  endtask
  // Pulse outputs are counted as they stand
  always @(posedge clk)
  begin
    n_fifo += fifo_valid;
    n_susp += suspend_irq;
    n_spec += special_irq;
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {nrst, bus_cs, bus_wr, bus_rd, tx_valid, req_suspend, req_resume} = 7'h00;
    {bus_addr, bus_wdata, modem_in, tx_data} = 24'h000000;
    repeat (3) @(negedge clk);
    chk({4'h0, tx_pin, ir_out, rts_n, dtr_n}, 8'h0b);
    nrst = 1'b1;
    rd(ADDR_MS, 8'h00);
    rd(ADDR_ISS, 8'h01);
    rd(ADDR_LS, 8'h60);
    rd(ADDR_EFC, 8'h00);
    rd(ADDR_CCS, 8'h00);
    // Pins show after two stages; the change is latched until read
    modem_in = 4'h5;
    repeat (4) @(negedge clk);
    rd(ADDR_MS, 8'h55);
    rd(ADDR_MS, 8'h50);
    for (int i = 1; i < 5; i++)
    begin
      rd(i[3:0], 8'h00);
      wr(i[3:0], ch[i]);
      rd(i[3:0], 8'h00);
    end
    rd(4'h9, 8'h00);
    req(1'b0);
    repeat (8) @(negedge clk);
    chk(8'(peer.got.size()), 8'h00);
    mode(8'h0a);
    req(1'b0);
    wait_got(1);
    chk(peer.got[0], 8'h11);
    rd(ADDR_CCS, 8'h08);
    rd(ADDR_CCS, 8'h00);
    req(1'b1);
    wait_got(2);
    chk(peer.got[1], 8'h13);
    rd(ADDR_CCS, 8'h04);
    peer.send(8'h13);
    repeat (3) @(negedge clk);
    // Data offered only once halted, so nothing may leave until resume
    tx_data = 8'h41;
    tx_valid = 1'b1;
    repeat (4) @(negedge clk);
    chk(tx_halted, 1'b1);
    chk(tx_ready, 1'b0);
    chk(8'(peer.got.size()), 8'h02);
    rd(ADDR_CCS, 8'h01);
    peer.send(8'h11);
    wait_got(3);
    chk(peer.got[2], 8'h41);
    tx_data = 8'h7e;
    wait_got(4);
    tx_valid = 1'b0;
    chk(peer.got[3], 8'h7e);
    rd(ADDR_CCS, 8'h02);
    req(1'b0);
    wait_got(5);
    wr(ADDR_EFC, 8'h00);
    rd(ADDR_CCS, 8'h00);
    mode(8'h0c);
    req(1'b0);
    wait_got(2);
    chk(peer.got[0], 8'h11);
    chk(peer.got[1], 8'h91);
    mode(8'h25);
    req(1'b1);
    wait_got(1);
    chk(peer.got[0], 8'h93);
    peer.send(8'h13);
    peer.send(8'h93);
    repeat (3) @(negedge clk);
    chk(8'(n_fifo), 8'h01);
    chk(8'(n_susp), 8'h01);
    chk(8'(n_spec), 8'h01);
    mode(8'h0b);
    peer.send(8'h93);
    repeat (3) @(negedge clk);
    chk(tx_halted, 1'b1);
    peer.send(8'h91);
    repeat (3) @(negedge clk);
    chk(tx_halted, 1'b0);
    mode(8'h03);
    peer.send(8'h13);
    peer.send(8'h41);
    peer.send(8'h93);
    repeat (3) @(negedge clk);
    chk(tx_halted, 1'b0);
    peer.send(8'h13);
    peer.send(8'h93);
    repeat (3) @(negedge clk);
    chk(tx_halted, 1'b1);
    req(1'b0);
    repeat (8) @(negedge clk);
    chk(8'(peer.got.size()), 8'h00);
    complete_run;
  end
endmodule
